// *** pllc_freq_mon.sv ***
/*
  Frequency monitor: measures the clock count between rising edges of a
  sampled input and flags it valid while every period is within the limit.
  Assumes the input is synchronous to ref_clk and slower than ref_clk/2.
*/
`timescale 1ns/100ps
`default_nettype none
module pllc_freq_mon (
  input wire logic ref_clk,
  input wire logic rst,
  pllc_mon_if.mon mon
);
  import pllc_pkg::*;

  logic prev_r;
  logic seen_r;
  logic [MON_W-1:0] cnt_r;
  logic [MON_W-1:0] cnt_nxt;
  logic valid_r;
  logic rise;

  assign rise = mon.sample_in & ~prev_r;
  assign mon.valid = valid_r;

  always_comb begin
    cnt_nxt = cnt_r;
    if (rise) begin
      cnt_nxt = MON_W'(1);
    end else if (cnt_r <= mon.limit) begin
      cnt_nxt = cnt_r + MON_W'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_r <= 1'b0;
      seen_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      prev_r <= mon.sample_in;
      cnt_r <= cnt_nxt;
      if (rise) begin
        seen_r <= 1'b1;
      end
    end
  end

  // A period that exceeds the limit without an edge drops validity at once.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      valid_r <= 1'b0;
    end else if (rise) begin
      valid_r <= seen_r && (cnt_r <= mon.limit);
    end else if (cnt_r > mon.limit) begin
      valid_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** pllc_mon_if.sv ***
/*
  Carrier between the register slice and one frequency monitor: the
  period limit, the sampled input and the validity result.
  Assumes all signals are synchronous to the register clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface pllc_mon_if;
  logic [pllc_pkg::MON_W-1:0] limit;
  logic sample_in;
  logic valid;
  modport ctrl (output limit, output sample_in, input valid);
  modport mon (input limit, input sample_in, output valid);
endinterface
`default_nettype wire

// *** pllc_pkg.sv ***
/*
  Shared constants for the PLL control register slice: register offsets,
  field positions, reset values, monitor timing and calibration states.
  Assumes a single 40 MHz register clock.
*/
`default_nettype none
package pllc_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [9:0] OFS_CAL_TRIGGER = 10'h018;
  localparam logic [9:0] OFS_SYNC_DELAY = 10'h019;
  localparam logic [9:0] OFS_STATUS_THRESH = 10'h01a;
  localparam logic [9:0] OFS_MON_STATUS = 10'h01f;
  localparam logic [9:0] OFS_VCO_DIV = 10'h1e0;
  localparam logic [9:0] OFS_TRANSFER = 10'h232;

  // Field positions.
  localparam int CAL_BIT = 0;
  localparam int SYNC_MODE_HI = 7;
  localparam int SYNC_MODE_LO = 6;
  localparam int REF_DLY_HI = 5;
  localparam int REF_DLY_LO = 3;
  localparam int FB_DLY_HI = 2;
  localparam int FB_DLY_LO = 0;
  localparam int STAT_DIV_BIT = 7;
  localparam int THRESH_BIT = 6;
  localparam int VCO_DIV_HI = 2;
  localparam int VCO_DIV_LO = 0;
  localparam int TRANSFER_BIT = 0;
  localparam int MS_PRI_REF_BIT = 0;
  localparam int MS_SEC_REF_BIT = 1;
  localparam int MS_VCO_BIT = 2;
  localparam int MS_CAL_BUSY_BIT = 3;
  localparam int MS_CAL_DONE_BIT = 4;

  // Reset values.
  localparam logic [7:0] RST_SYNC_DELAY = 8'h00;
  localparam logic [1:0] RST_STATUS_THRESH = 2'h0;
  localparam logic RST_CAL_TRIGGER = 1'b0;
  localparam logic [2:0] RST_VCO_DIV = 3'h0;

  // Counter reset modes selected by the sync field.
  typedef enum logic [1:0] {
    PLLC_SYNC_NONE = 2'b00,
    PLLC_SYNC_ASYNC = 2'b01,
    PLLC_SYNC_SYNC = 2'b10,
    PLLC_SYNC_NONE2 = 2'b11
  } pllc_sync_mode_t;

  // Calibration engine states, Gray coded along idle, run, done.
  typedef enum logic [1:0] {
    PLLC_CAL_IDLE = 2'b00,
    PLLC_CAL_RUN = 2'b01,
    PLLC_CAL_DONE = 2'b11
  } pllc_cal_state_t;

  // Timing. A reference is valid when its period is under 1/f.
  localparam int CLK_HZ = 40_000_000;
  localparam int REF_HI_FREQ_HZ = 1_020_000;
  localparam int REF_LO_FREQ_HZ = 6_000;
  localparam int REF_HI_PERIOD_CYC = CLK_HZ / REF_HI_FREQ_HZ;
  localparam int REF_LO_PERIOD_CYC = CLK_HZ / REF_LO_FREQ_HZ;
  localparam int VCO_MON_PERIOD_CYC = 16;
  localparam int CAL_CYCLES = 64;
  localparam int MON_W = 14;
endpackage
`default_nettype wire

// *** pllc_top.sv ***
/*
  PLL control register slice: buffered and active register copies, VCO
  calibration trigger, counter sync reset mode, path delay fields, status
  pin divider and reference frequency monitors.
  Assumes a register port synchronous to ref_clk with one-cycle strobes.
*/
// What this block does
// - Calibration trigger bit resets to zero
// - Sync field: none, async, sync, none
// - Reference and feedback delay fields reset zero
// - Status bit 7 divides status pin by four
// - Threshold zero: reference valid above 1.02 MHz
// - Threshold one: reference valid above 6 kHz
// - Threshold leaves VCO monitor unchanged
`timescale 1ns/100ps
`default_nettype none
module pllc_top #(
  parameter int REF_LO_LIMIT = pllc_pkg::REF_LO_PERIOD_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [pllc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pllc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pllc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic sync_n,
  output logic counter_rst_async,
  output logic counter_rst_sync,
  output logic [2:0] ref_path_delay,
  output logic [2:0] fb_path_delay,
  output logic [2:0] vco_div_sel,
  input wire logic status_src,
  output logic status_pin,
  input wire logic primary_reference_input,
  input wire logic secondary_reference_input,
  input wire logic vco_mon_in,
  output logic primary_ref_valid,
  output logic secondary_ref_valid,
  output logic vco_valid,
  output logic cal_start,
  output logic cal_busy
);
  import pllc_pkg::*;

  // Buffered copies, written by software.
  logic [7:0] buf_sync_delay_r;
  logic [1:0] buf_status_thresh_r;
  logic buf_cal_r;
  logic [2:0] buf_vco_div_r;

  // Active copies, which alone steer the hardware.
  logic [7:0] act_sync_delay_r;
  logic [1:0] act_status_thresh_r;
  logic act_cal_r;
  logic act_cal_prev_r;
  logic [2:0] act_vco_div_r;

  logic transfer;
  logic wr_sync_delay;
  logic wr_status_thresh;
  logic wr_cal;
  logic wr_vco_div;

  pllc_cal_state_t cal_state_r;
  pllc_cal_state_t cal_state_nxt;
  logic [7:0] cal_cnt_r;
  logic cal_start_r;

  pllc_sync_mode_t sync_mode;
  logic counter_rst_sync_r;

  logic status_prev_r;
  logic [1:0] status_div_r;
  logic status_pin_r;

  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rd_mux;

  pllc_mon_if pri_ref_if ();
  pllc_mon_if sec_ref_if ();
  pllc_mon_if vco_if ();

  assign wr_sync_delay = reg_wr && (reg_addr == OFS_SYNC_DELAY);
  assign wr_status_thresh = reg_wr && (reg_addr == OFS_STATUS_THRESH);
  assign wr_cal = reg_wr && (reg_addr == OFS_CAL_TRIGGER);
  assign wr_vco_div = reg_wr && (reg_addr == OFS_VCO_DIV);
  // The transfer bit is self-clearing and acts as a one-cycle strobe.
  assign transfer = reg_wr && (reg_addr == OFS_TRANSFER) && reg_wdata[TRANSFER_BIT];

  // Buffered register writes.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      buf_sync_delay_r <= RST_SYNC_DELAY;
      buf_status_thresh_r <= RST_STATUS_THRESH;
      buf_cal_r <= RST_CAL_TRIGGER;
      buf_vco_div_r <= RST_VCO_DIV;
    end else begin
      if (wr_sync_delay) begin
        buf_sync_delay_r <= reg_wdata;
      end
      if (wr_status_thresh) begin
        buf_status_thresh_r <= reg_wdata[STAT_DIV_BIT:THRESH_BIT];
      end
      if (wr_cal) begin
        buf_cal_r <= reg_wdata[CAL_BIT];
      end
      if (wr_vco_div) begin
        buf_vco_div_r <= reg_wdata[VCO_DIV_HI:VCO_DIV_LO];
      end
    end
  end

  // All buffered values move to the active copies in the same cycle, except the VCO divider while calibration is busy.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      act_sync_delay_r <= RST_SYNC_DELAY;
      act_status_thresh_r <= RST_STATUS_THRESH;
      act_cal_r <= RST_CAL_TRIGGER;
      act_vco_div_r <= RST_VCO_DIV;
    end else if (transfer) begin
      act_sync_delay_r <= buf_sync_delay_r;
      act_status_thresh_r <= buf_status_thresh_r;
      act_cal_r <= buf_cal_r;
      // A running calibration keeps the divider it started with.
      if (!cal_busy) begin
        act_vco_div_r <= buf_vco_div_r;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      act_cal_prev_r <= 1'b0;
    end else begin
      act_cal_prev_r <= act_cal_r;
    end
  end

  // Calibration engine, started only by a low-to-high active trigger.
  always_comb begin
    cal_state_nxt = cal_state_r;
    case (cal_state_r)
      PLLC_CAL_IDLE: begin
        if (act_cal_r && !act_cal_prev_r) begin
          cal_state_nxt = PLLC_CAL_RUN;
        end
      end
      PLLC_CAL_RUN: begin
        if (cal_cnt_r == 8'(CAL_CYCLES - 1)) begin
          cal_state_nxt = PLLC_CAL_DONE;
        end
      end
      PLLC_CAL_DONE: begin
        if (!act_cal_r) begin
          cal_state_nxt = PLLC_CAL_IDLE;
        end
      end
      default: begin
        cal_state_nxt = PLLC_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cal_state_r <= PLLC_CAL_IDLE;
      cal_cnt_r <= 8'h00;
      cal_start_r <= 1'b0;
    end else begin
      cal_state_r <= cal_state_nxt;
      cal_start_r <= (cal_state_r == PLLC_CAL_IDLE) && (cal_state_nxt == PLLC_CAL_RUN);
      if (cal_state_r == PLLC_CAL_RUN) begin
        cal_cnt_r <= cal_cnt_r + 8'h01;
      end else begin
        cal_cnt_r <= 8'h00;
      end
    end
  end

  assign cal_start = cal_start_r;
  assign cal_busy = (cal_state_r == PLLC_CAL_RUN);

  // Counter reset from the sync pin, per the active mode field.
  assign sync_mode = pllc_sync_mode_t'(act_sync_delay_r[SYNC_MODE_HI:SYNC_MODE_LO]);
  assign counter_rst_async = (sync_mode == PLLC_SYNC_ASYNC) && !sync_n;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      counter_rst_sync_r <= 1'b0;
    end else begin
      counter_rst_sync_r <= (sync_mode == PLLC_SYNC_SYNC) && !sync_n;
    end
  end

  assign counter_rst_sync = counter_rst_sync_r;

  assign ref_path_delay = act_sync_delay_r[REF_DLY_HI:REF_DLY_LO];
  assign fb_path_delay = act_sync_delay_r[FB_DLY_HI:FB_DLY_LO];
  assign vco_div_sel = act_vco_div_r;

  // Status pin: plain copy, or one output period per four input periods.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_prev_r <= 1'b0;
      status_div_r <= 2'b00;
      status_pin_r <= 1'b0;
    end else begin
      status_prev_r <= status_src;
      if (status_src && !status_prev_r) begin
        status_div_r <= status_div_r + 2'b01;
      end
      if (act_status_thresh_r[1]) begin
        status_pin_r <= status_div_r[1];
      end else begin
        status_pin_r <= status_src;
      end
    end
  end

  assign status_pin = status_pin_r;

  // Reference monitors follow the threshold bit; the VCO monitor does not.
  // Both reference monitors share one limit, so the threshold bit moves them
  // together and a change takes effect only at the next transfer.
  assign pri_ref_if.limit = act_status_thresh_r[0] ? MON_W'(REF_LO_LIMIT)
                                                   : MON_W'(REF_HI_PERIOD_CYC);
  assign sec_ref_if.limit = act_status_thresh_r[0] ? MON_W'(REF_LO_LIMIT)
                                                   : MON_W'(REF_HI_PERIOD_CYC);
  assign vco_if.limit = MON_W'(VCO_MON_PERIOD_CYC);
  assign pri_ref_if.sample_in = primary_reference_input;
  assign sec_ref_if.sample_in = secondary_reference_input;
  assign vco_if.sample_in = vco_mon_in;

  pllc_freq_mon u_pri_ref_mon (
    .ref_clk(ref_clk),
    .rst(rst),
    .mon(pri_ref_if.mon)
  );

  pllc_freq_mon u_sec_ref_mon (
    .ref_clk(ref_clk),
    .rst(rst),
    .mon(sec_ref_if.mon)
  );

  pllc_freq_mon u_vco_mon (
    .ref_clk(ref_clk),
    .rst(rst),
    .mon(vco_if.mon)
  );

  assign primary_ref_valid = pri_ref_if.valid;
  assign secondary_ref_valid = sec_ref_if.valid;
  assign vco_valid = vco_if.valid;

  // Read mux: writable registers return their buffered copy.
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      OFS_CAL_TRIGGER: begin
        rd_mux[CAL_BIT] = buf_cal_r;
      end
      OFS_SYNC_DELAY: begin
        rd_mux = buf_sync_delay_r;
      end
      OFS_STATUS_THRESH: begin
        rd_mux[STAT_DIV_BIT:THRESH_BIT] = buf_status_thresh_r;
      end
      OFS_VCO_DIV: begin
        rd_mux[VCO_DIV_HI:VCO_DIV_LO] = buf_vco_div_r;
      end
      OFS_MON_STATUS: begin
        rd_mux[MS_PRI_REF_BIT] = pri_ref_if.valid;
        rd_mux[MS_SEC_REF_BIT] = sec_ref_if.valid;
        rd_mux[MS_VCO_BIT] = vco_if.valid;
        rd_mux[MS_CAL_BUSY_BIT] = cal_busy;
        rd_mux[MS_CAL_DONE_BIT] = (cal_state_r == PLLC_CAL_DONE);
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Read data stands for exactly one cycle after the read strobe.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      rdata_r <= rd_mux;
    end else begin
      rdata_r <= '0;
    end
  end

  assign reg_rdata = rdata_r;
endmodule
`default_nettype wire

// *** pllc_top_props.sv ***
/*
  Checker for the PLL control slice: mirrors the buffered and active copies.
  Assumes it is bound to pllc_top and sees only the top module's ports.
*/
`timescale 1ns/100ps
`default_nettype none
module pllc_top_props
  import pllc_pkg::*;
#(
  parameter int REF_LO_LIMIT = 6666
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [pllc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pllc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic sync_n,
  input wire logic counter_rst_async,
  input wire logic counter_rst_sync,
  input wire logic [2:0] ref_path_delay,
  input wire logic [2:0] fb_path_delay,
  input wire logic [2:0] vco_div_sel,
  input wire logic status_src,
  input wire logic status_pin,
  input wire logic primary_reference_input,
  input wire logic primary_ref_valid,
  input wire logic cal_start,
  input wire logic cal_busy
);
  logic [7:0] sd_b_r, sd_a_r, busy_cnt_r;
  logic [1:0] st_b_r, st_a_r;
  logic cb_r, ca_r, pin_d_r, xfer;
  logic [15:0] gap_r;
  assign xfer = reg_wr && reg_addr == OFS_TRANSFER && reg_wdata[TRANSFER_BIT];
  // Mirror of the two register copies, seen only through the port.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sd_b_r <= 8'h00;
      sd_a_r <= 8'h00;
      st_b_r <= 2'h0;
      st_a_r <= 2'h0;
      cb_r <= 1'b0;
      ca_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == OFS_SYNC_DELAY) sd_b_r <= reg_wdata;
      if (reg_wr && reg_addr == OFS_STATUS_THRESH) st_b_r <= reg_wdata[7:6];
      if (reg_wr && reg_addr == OFS_CAL_TRIGGER) cb_r <= reg_wdata[CAL_BIT];
      if (xfer) begin
        sd_a_r <= sd_b_r;
        st_a_r <= st_b_r;
        ca_r <= cb_r;
      end
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) busy_cnt_r <= 8'h00;
    else busy_cnt_r <= cal_busy ? busy_cnt_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_d_r <= 1'b0;
      gap_r <= 16'h0000;
    end else begin
      pin_d_r <= primary_reference_input;
      if (primary_reference_input && !pin_d_r) gap_r <= 16'h0000;
      else gap_r <= gap_r + 16'(gap_r != 16'hffff);
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_cal_rise;
    $rose(ca_r) && !cal_busy;
  endsequence
  sequence s_cal_run;
    ##[1:3] cal_busy ##[0:2] cal_start;
  endsequence
  AST_CAL_START: assert property (s_cal_rise |-> s_cal_run)
    else $error("calibration did not start after active trigger rise");
  AST_CAL_CAUSE: assert property ($rose(cal_busy) |-> ca_r)
    else $error("calibration ran without an active trigger");
  AST_CAL_LEN: assert property ($fell(cal_busy) |-> busy_cnt_r == CAL_CYCLES)
    else $error("calibration length wrong");
  AST_DIV_HOLD: assert property (cal_busy && $past(cal_busy) |-> $stable(vco_div_sel))
    else $error("divider moved during calibration");
  AST_SYNC_ASYNC: assert property (counter_rst_async == (sd_a_r[7:6] == 2'b01 && !sync_n))
    else $error("asynchronous counter reset wrong");
  AST_SYNC_SYNC: assert property (counter_rst_sync ==
    ($past(sd_a_r[7:6]) == 2'b10 && !$past(sync_n)))
    else $error("synchronous counter reset wrong");
  AST_DELAYS: assert property ({ref_path_delay, fb_path_delay} == sd_a_r[5:0])
    else $error("path delay outputs differ from active copy");
  AST_STAT_DIRECT: assert property (!st_a_r[1] && !$past(st_a_r[1]) |->
    status_pin == $past(status_src))
    else $error("status pin not following source");
  AST_STAT_DIV: assert property (st_a_r[1] && $past(st_a_r[1]) && $past(st_a_r[1], 2) &&
    $rose(status_pin) |-> ##1 (status_pin || !st_a_r[1]) [*3])
    else $error("divided status pin too short");
  AST_REF_FAST: assert property (primary_ref_valid && !st_a_r[0] &&
    !$past(st_a_r[0], 2) |-> gap_r <= 16'h002a)
    else $error("reference valid below the high threshold");
  AST_REF_SLOW: assert property (primary_ref_valid |-> gap_r <= REF_LO_LIMIT + 3)
    else $error("reference valid below the low threshold");
endmodule
bind pllc_top pllc_top_props #(.REF_LO_LIMIT(REF_LO_LIMIT)) u_props (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .sync_n(sync_n), .counter_rst_async(counter_rst_async),
  .counter_rst_sync(counter_rst_sync), .ref_path_delay(ref_path_delay),
  .fb_path_delay(fb_path_delay), .vco_div_sel(vco_div_sel), .status_src(status_src),
  .status_pin(status_pin), .primary_reference_input(primary_reference_input),
  .primary_ref_valid(primary_ref_valid), .cal_start(cal_start), .cal_busy(cal_busy));
`default_nettype wire

// *** pllc_top_tb_top.sv ***
/*
  Self-checking bench for the PLL control slice with a read scoreboard.
  Assumes the package, design and checker are compiled before this file.
*/
`timescale 1ns/100ps
`default_nettype none
module pllc_top_tb_top;
  import pllc_pkg::*;
  localparam int LO_LIM = 100;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 10'h000;
  logic [DATA_W-1:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, sync_n = 1'b1, status_src = 1'b0, rd_prev = 1'b0;
  logic pri_in = 1'b0, sec_in = 1'b0, vco_in = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic c_async, c_sync, s_pin, p_ok, s_ok, v_ok, c_start, c_busy;
  logic [2:0] r_dly, f_dly, v_div;
  logic [7:0] exp_q[$];
  logic [7:0] v;
  int bad_count = 0, cmp_count = 0, k, tg;
  int pp[2] = '{20, 60};
  int sp[2] = '{60, 150};
  int vp[2] = '{8, 20};
  always #12.5 ref_clk = ~ref_clk;
  pllc_top #(.REF_LO_LIMIT(LO_LIM)) dut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_n(sync_n),
    .counter_rst_async(c_async), .counter_rst_sync(c_sync), .ref_path_delay(r_dly),
    .fb_path_delay(f_dly), .vco_div_sel(v_div), .status_src(status_src),
    .status_pin(s_pin), .primary_reference_input(pri_in),
    .secondary_reference_input(sec_in), .vco_mon_in(vco_in), .primary_ref_valid(p_ok),
    .secondary_ref_valid(s_ok), .vco_valid(v_ok), .cal_start(c_start), .cal_busy(c_busy));
  task end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Read data stand only in the cycle after the strobe.
  always @(posedge ref_clk) rd_prev <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_prev && exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front(), "read data");
  end
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
  endtask
  task xfer;
    wr(OFS_TRANSFER, 8'h01);
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task wait_busy(input logic lvl);
    for (k = 0; k < 200 && c_busy !== lvl; k++) @(posedge ref_clk);
    chk(8'(c_busy), 8'(lvl), "calibration busy wait");
    if (c_busy !== lvl) end_of_test;
  endtask
  initial begin
    v = 8'($urandom(32'ha43d1694));
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_CAL_TRIGGER, 8'h00);
    rd(OFS_SYNC_DELAY, 8'h00);
    rd(OFS_STATUS_THRESH, 8'h00);
    rd(10'h3ff, 8'h00);
    tick(2);
    chk(8'(c_busy), 8'h00, "busy after reset");
    $display("test reset values done");
    v = 8'($urandom) & 8'h3f;
    wr(OFS_SYNC_DELAY, v);
    tick(2);
    chk(8'({r_dly, f_dly}), 8'h00, "delays before transfer");
    xfer;
    tick(1);
    chk(8'({r_dly, f_dly}), v, "delays after transfer");
    rd(OFS_SYNC_DELAY, v);
    $display("test path delays done");
    for (int m = 0; m < 4; m++) begin
      wr(OFS_SYNC_DELAY, {2'(m), 6'h00});
      xfer;
      sync_n <= 1'b0;
      tick(2);
      chk({6'h00, c_async, c_sync}, {6'h00, m == 1, m == 2}, "sync mode");
      @(posedge ref_clk);
      sync_n <= 1'b1;
    end
    $display("test sync modes done");
    wr(OFS_VCO_DIV, 8'h02);
    xfer;
    wr(OFS_CAL_TRIGGER, 8'h00);
    xfer;
    wr(OFS_CAL_TRIGGER, 8'h01);
    tick(6);
    chk(8'(c_busy), 8'h00, "buffered trigger only");
    xfer;
    wait_busy(1'b1);
    wr(OFS_VCO_DIV, 8'h05);
    xfer;
    tick(1);
    chk(8'(v_div), 8'h02, "divider held");
    rd(OFS_VCO_DIV, 8'h05);
    rd(OFS_MON_STATUS, 8'h08);
    wait_busy(1'b0);
    rd(OFS_MON_STATUS, 8'h10);
    xfer;
    tick(1);
    chk(8'(v_div), 8'h05, "divider after calibration");
    tick(6);
    chk(8'(c_busy), 8'h00, "trigger one to one");
    $display("test calibration done");
    for (k = 0; k < 16; k++) begin
      @(posedge ref_clk);
      v[0] = status_src;
      status_src <= 1'($urandom);
      #1;
      chk(8'(s_pin), 8'(v[0]), "status direct");
    end
    wr(OFS_STATUS_THRESH, 8'h80);
    xfer;
    // Let the mode switch settle before counting pin toggles.
    tick(1);
    tg = 0;
    v[1] = s_pin;
    for (k = 0; k < 32; k++) begin
      @(posedge ref_clk);
      status_src <= ~status_src;
      #1;
      if (s_pin !== v[1]) tg++;
      v[1] = s_pin;
    end
    chk(8'(tg >= 7 && tg <= 8), 8'h01, "status divide by four");
    $display("test status pin done");
    for (int t = 0; t < 2; t++) begin
      wr(OFS_STATUS_THRESH, t == 0 ? 8'h00 : 8'h40);
      xfer;
      for (k = 0; k < 400; k++) begin
        @(posedge ref_clk);
        pri_in <= k % pp[t] == 0;
        sec_in <= k % sp[t] == 0;
        vco_in <= k % vp[t] == 0;
      end
      #1;
      chk({5'h00, p_ok, s_ok, v_ok}, t == 0 ? 8'h05 : 8'h04, "monitors");
    end
    rd(OFS_MON_STATUS, 8'h11);
    $display("test monitors done");
    repeat (2) @(posedge ref_clk);
    status_src <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(OFS_CAL_TRIGGER, 8'h00);
    rd(OFS_MON_STATUS, 8'h00);
    $display("test mid-run reset done");
    tick(3);
    end_of_test;
  end
endmodule
`default_nettype wire
